/* drac_ctrl.sv */
// How it works
// - Area configuration acts only while the DRAM space enable is set.
// - Both control registers clear on power-on reset, kept on manual reset.
// - Wide access: strobe bit 0 dual CAS, bit 1 dual write strobes.
// - Narrow access drives only low CAS and low write strobe.
// - RAS hold bit 0 raises RAS between accesses; 1 keeps it low.
// - Precharge lasts one state, or two when precharge length is set.
// - Burst off: every access is full, row address always output.
// - Burst on with same row: column address and CAS only.
// - Short pitch CAS high for 50% of state, or 35% with duty set.
// - Row and column share address lines only with mux enable set.
// - Mux shift codes 00, 01, 10 shift row down by 8, 9, 10.
// - Burst compare covers A8, A9 or A10 up to A27, mux or not.
// - Reserved bits read zero; software writes zero there.
// - Refresh control changes only by keyed 16-bit word write.
// - Refresh enable clear means no refresh; timer still counts.
// - Refresh mode 0 gives timed CAS-before-RAS; 1 gives self-refresh.
// - Refresh mode ignored while refresh enable is clear.
// - With refresh wait enabled, CAS_BEFORE_RAS_REFRESH inserts 1 to 4 wait states.
// - With refresh wait disabled, CAS_BEFORE_RAS_REFRESH inserts no wait states.
// - Timer match clears counter, sets flag, and requests refresh when CAS-before-RAS refresh is on.
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module drac_ctrl
  import drac_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic man_rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic req,
  input wire logic [AW-1:0] req_addr,
  input wire logic req_write,
  input wire logic req_wide,
  input wire logic req_hi,
  input wire logic req_lo,
  output logic req_ready,
  output logic ack,
  output logic ras_b,
  output logic cas_high_byte_b,
  output logic cas_low_byte_b,
  output logic write_strobe_high_b,
  output logic write_strobe_low_b,
  output logic [AW-1:0] dram_addr
);
  logic [15:0] dac_raw;
  logic [15:0] rfc;
  logic [1:0] cfg;
  logic [7:0] cmp;
  logic [PH_W-1:0] phase;
  logic sten;
  logic fsm_rst;
  logic match;
  drac_state_e st;
  drac_state_e after_pre;
  logic [2:0] cnt;
  logic row_open;
  logic [AW-1:0] last_row;
  logic [AW-1:0] a_addr;
  logic a_write;
  logic a_wide;
  logic a_hi;
  logic a_lo;
  logic ref_pend;
  logic [TMR_W-1:0] rcnt;

  function automatic logic [4:0] row_shift(input logic [1:0] code);
    // Reserved code 11 falls back to the smallest shift
    if (code == 2'b01) begin
      row_shift = 5'd9;
    end else if (code == 2'b10) begin
      row_shift = 5'd10;
    end else begin
      row_shift = 5'd8;
    end
  endfunction

  function automatic logic [AW-1:0] row_mask(input logic [1:0] code);
    row_mask = ~((AW'(1) << row_shift(code)) - AW'(1));
  endfunction

  drac_apb u_apb (
    .clk(clk),
    .rst_b(rst_b),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .match(match),
    .fsm_state(st),
    .dac(dac_raw),
    .rfc(rfc),
    .cfg(cfg),
    .cmp(cmp),
    .flag()
  );

  drac_phase #(.CYC(STATE_CYC)) u_phase (
    .clk(clk),
    .rst_b(rst_b),
    .phase(phase),
    .sten(sten)
  );

  logic dram_en;
  logic [15:0] dac;
  logic strobe2;
  logic ras_hold;
  logic pre_len;
  logic burst;
  logic duty;
  logic mux_en;
  logic [1:0] shsel;
  logic rf_en;
  logic rf_self;
  logic rf_cbr;
  logic [2:0] waits;
  logic [2:0] pre_max;
  logic [PH_W-1:0] hi_cyc;
  logic row_hit;
  logic take;

  assign fsm_rst = !rst_b || !man_rst_b;
  assign dram_en = cfg[CFG_DRAM_EN];
  assign dac = dram_en ? dac_raw : 16'h0000;
  assign strobe2 = dac[DAC_STROBE];
  assign ras_hold = dac[DAC_RAS_HOLD];
  assign pre_len = dac[DAC_PRE_LEN];
  assign burst = dac[DAC_BURST];
  assign duty = dac[DAC_DUTY];
  assign mux_en = dac[DAC_MUX];
  assign shsel = dac[DAC_SHIFT_LO +: 2];
  assign rf_en = rfc[RFC_EN] && dram_en;
  assign rf_self = rf_en && rfc[RFC_MODE];
  assign rf_cbr = rf_en && !rfc[RFC_MODE];
  // Wait states are fixed by the code; the external wait pin plays no part
  assign waits = cfg[CFG_RWAIT_EN] ?
    {1'b0, rfc[RFC_WAIT_LO +: 2]} + 3'd1 : 3'd0;
  assign pre_max = pre_len ? 3'd1 : 3'd0;
  assign hi_cyc = duty ? PH_W'(CAS_HI_35) : PH_W'(CAS_HI_50);
  assign row_hit = row_open &&
    ((req_addr ^ last_row) & row_mask(shsel)) == '0;
  assign req_ready = st == ST_IDLE && sten && dram_en && !ref_pend &&
    !rf_self;
  assign take = req && req_ready;
  assign ack = st == ST_COL && sten;

  // Timer runs whether refresh is on or not, usable as interval timer
  assign match = sten && rcnt == cmp;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rcnt <= '0;
    end else if (match) begin
      rcnt <= '0;
    end else if (sten) begin
      rcnt <= rcnt + TMR_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (fsm_rst) begin
      ref_pend <= 1'b0;
    end else if (match && rf_cbr) begin
      ref_pend <= 1'b1;
    end else if (!rf_cbr || (st == ST_CBR && sten && cnt == waits)) begin
      ref_pend <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (fsm_rst) begin
      a_addr <= '0;
      a_write <= 1'b0;
      a_wide <= 1'b0;
      a_hi <= 1'b0;
      a_lo <= 1'b0;
    end else if (take) begin
      a_addr <= req_addr;
      a_write <= req_write;
      a_wide <= req_wide;
      a_hi <= req_hi;
      a_lo <= req_lo;
    end
  end

  always_ff @(posedge clk) begin
    if (fsm_rst) begin
      st <= ST_IDLE;
      after_pre <= ST_IDLE;
      cnt <= 3'd0;
      row_open <= 1'b0;
      last_row <= '0;
    end else if (sten) begin
      case (st)
        ST_IDLE: begin
          cnt <= 3'd0;
          if (!dram_en && row_open) begin
            st <= ST_PRE;
            after_pre <= ST_IDLE;
            row_open <= 1'b0;
          end else if (rf_self) begin
            st <= row_open ? ST_PRE : ST_SELF;
            after_pre <= ST_SELF;
            row_open <= 1'b0;
          end else if (ref_pend) begin
            st <= row_open ? ST_PRE : ST_CBR;
            after_pre <= ST_CBR;
            row_open <= 1'b0;
          end else if (take) begin
            if (burst && row_hit) begin
              st <= ST_COL;
            end else if (row_open) begin
              st <= ST_PRE;
              after_pre <= ST_ROW;
              row_open <= 1'b0;
            end else begin
              st <= ST_ROW;
            end
          end else if (row_open && !ras_hold) begin
            // Hold bit cleared with a row open: close it, RAS goes up
            st <= ST_PRE;
            after_pre <= ST_IDLE;
            row_open <= 1'b0;
          end
        end
        ST_PRE: begin
          if (cnt == pre_max) begin
            st <= after_pre;
            cnt <= 3'd0;
          end else begin
            cnt <= cnt + 3'd1;
          end
        end
        ST_ROW: begin
          st <= ST_COL;
          row_open <= 1'b1;
          last_row <= a_addr;
        end
        ST_COL: begin
          if (ras_hold) begin
            st <= ST_IDLE;
          end else begin
            st <= ST_PRE;
            after_pre <= ST_IDLE;
            row_open <= 1'b0;
          end
        end
        ST_CBR: begin
          if (cnt == waits) begin
            st <= ST_PRE;
            after_pre <= ST_IDLE;
            cnt <= 3'd0;
          end else begin
            cnt <= cnt + 3'd1;
          end
        end
        ST_SELF: begin
          // Leaves once mode or refresh enable is cleared, or DRAM space is disabled
          if (!rf_self) begin
            st <= ST_PRE;
            after_pre <= ST_IDLE;
          end
        end
        default: begin
          st <= ST_IDLE;
        end
      endcase
    end
  end

  logic cas_on;
  logic cbr_cas;
  logic ras_on;

  // CAS leads RAS in the CBR state; RAS drops at mid-state (self-refresh drops both together)
  assign cas_on = st == ST_COL && phase >= hi_cyc;
  assign cbr_cas = st == ST_CBR || st == ST_SELF;
  assign ras_on = st == ST_ROW || st == ST_COL || st == ST_SELF ||
    (st == ST_IDLE && row_open) ||
    (st == ST_CBR && (cnt != 3'd0 || phase >= PH_W'(STATE_CYC / 2)));

  always_ff @(posedge clk) begin
    if (fsm_rst) begin
      ras_b <= 1'b1;
      cas_high_byte_b <= 1'b1;
      cas_low_byte_b <= 1'b1;
      write_strobe_high_b <= 1'b1;
      write_strobe_low_b <= 1'b1;
    end else begin
      ras_b <= !ras_on;
      if (cbr_cas) begin
        cas_high_byte_b <= 1'b0;
        cas_low_byte_b <= 1'b0;
        write_strobe_high_b <= 1'b1;
        write_strobe_low_b <= 1'b1;
      end else if (!a_wide) begin
        cas_high_byte_b <= 1'b1;
        cas_low_byte_b <= !cas_on;
        write_strobe_high_b <= 1'b1;
        write_strobe_low_b <= !(cas_on && a_write);
      end else if (!strobe2) begin
        cas_high_byte_b <= !(cas_on && a_hi);
        cas_low_byte_b <= !(cas_on && a_lo);
        write_strobe_high_b <= 1'b1;
        write_strobe_low_b <= !(cas_on && a_write);
      end else begin
        cas_high_byte_b <= 1'b1;
        cas_low_byte_b <= !cas_on;
        write_strobe_high_b <= !(cas_on && a_write && a_hi);
        write_strobe_low_b <= !(cas_on && a_write && a_lo);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (fsm_rst) begin
      dram_addr <= '0;
    end else if (st == ST_ROW && mux_en) begin
      dram_addr <= a_addr >> row_shift(shsel);
    end else begin
      dram_addr <= a_addr;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (fsm_rst);

  sequence s_miss_pre;
    st == ST_PRE ##1 (st == ST_PRE)[*1];
  endsequence

  AST_DISABLED_IDLE: assert property (
    !dram_en && st == ST_IDLE |=> st != ST_ROW && st != ST_COL)
    else $error("request taken with DRAM space disabled");
  AST_NARROW_STROBES: assert property (
    st == ST_COL && !a_wide |=> cas_high_byte_b && write_strobe_high_b)
    else $error("high strobes active on narrow access");
  AST_DUAL_CAS: assert property (
    st == ST_COL && a_wide && !strobe2 |=> write_strobe_high_b)
    else $error("high write strobe active in dual CAS");
  AST_RAS_UP: assert property (
    ack && !ras_hold |=> st == ST_PRE ##1 ras_b)
    else $error("RAS not raised after access");
  AST_PRE_LEN: assert property (
    st == ST_PRE && sten && cnt < pre_max |=> st == ST_PRE)
    else $error("precharge cut short");
  AST_PRE_END: assert property (
    st == ST_PRE && sten && cnt == pre_max |=> st != ST_PRE)
    else $error("precharge too long");
  AST_FULL_ACCESS: assert property (
    take && !burst |=> st == ST_ROW || st == ST_PRE)
    else $error("burst off but row skipped");
  AST_FAST_PAGE: assert property (
    take && burst && row_hit |=> st == ST_COL ##1 ras_b == 1'b0)
    else $error("page hit did not go to column");
  AST_ROW_MISS: assert property (
    take && row_open && !row_hit |=> s_miss_pre)
    else $error("row miss without precharge");
  AST_CAS_DUTY: assert property (
    st == ST_COL && phase < hi_cyc |=> cas_low_byte_b)
    else $error("CAS low inside high portion");
  AST_MUX_ROW: assert property (
    st == ST_ROW && mux_en |=> dram_addr == a_addr >> row_shift(shsel))
    else $error("row address shift wrong");
  AST_CBR_WAIT: assert property (
    st == ST_CBR && sten && cnt == waits |=> st == ST_PRE)
    else $error("refresh wait count wrong");
  AST_SELF_HOLD: assert property (
    st == ST_SELF && rf_self |=> st == ST_SELF && !ras_b)
    else $error("self-refresh dropped");
  AST_TIMER_CLEAR: assert property (
    match |=> rcnt == '0)
    else $error("timer not cleared on match");
endmodule // drac_ctrl
`default_nettype wire

/* drac_pkg.sv */
`default_nettype none
package drac_pkg;
  localparam int CLK_NS = 50;
  localparam int STATE_NS = 1000;
  localparam int STATE_CYC = STATE_NS / CLK_NS;
  localparam int CAS_HI_50 = STATE_CYC * 50 / 100;
  localparam int CAS_HI_35 = STATE_CYC * 35 / 100;
  localparam int PH_W = 5;
  localparam int AW = 28;
  localparam int TMR_W = 8;

  localparam logic [7:0] OFS_DAC = 8'h00;
  localparam logic [7:0] OFS_RFC = 8'h04;
  localparam logic [7:0] OFS_CFG = 8'h08;
  localparam logic [7:0] OFS_CMP = 8'h0c;
  localparam logic [7:0] OFS_STS = 8'h10;

  localparam int DAC_STROBE = 15;
  localparam int DAC_RAS_HOLD = 14;
  localparam int DAC_PRE_LEN = 13;
  localparam int DAC_BURST = 12;
  localparam int DAC_DUTY = 11;
  localparam int DAC_MUX = 10;
  localparam int DAC_SHIFT_LO = 8;
  localparam int RFC_EN = 7;
  localparam int RFC_MODE = 6;
  localparam int RFC_WAIT_LO = 4;
  localparam int CFG_DRAM_EN = 0;
  localparam int CFG_RWAIT_EN = 1;
  localparam int STS_FLAG = 7;

  localparam logic [7:0] RFC_KEY = 8'h5a;
  localparam logic [7:0] DAC_RST = 8'h00;
  localparam logic [3:0] RFC_RST = 4'h0;
  localparam logic [1:0] CFG_RST = 2'h0;
  localparam logic [7:0] CMP_RST = 8'hff;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PRE = 3'b001,
    ST_ROW = 3'b010,
    ST_COL = 3'b011,
    ST_CBR = 3'b100,
    ST_SELF = 3'b101
  } drac_state_e;
endpackage
`default_nettype wire

/* drac_phase.sv */
`timescale 1ns/1ps
`default_nettype none
module drac_phase
  import drac_pkg::*;
#(
  parameter int CYC = STATE_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  output logic [PH_W-1:0] phase,
  output logic sten
);
  assign sten = (phase == PH_W'(CYC - 1));

  always_ff @(posedge clk) begin
    if (!rst_b || sten) begin
      phase <= '0;
    end else begin
      phase <= phase + PH_W'(1);
    end
  end
endmodule // drac_phase
`default_nettype wire

/* drac_apb.sv */
`timescale 1ns/1ps
`default_nettype none
module drac_apb
  import drac_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic match,
  input wire logic [2:0] fsm_state,
  output logic [15:0] dac,
  output logic [15:0] rfc,
  output logic [1:0] cfg,
  output logic [7:0] cmp,
  output logic flag
);
  logic [7:0] dac_hi;
  logic [3:0] rfc_hi;
  logic hit;
  logic wr;
  logic [15:0] rd;

  // Reserved bits are never stored, so they always read zero
  assign dac = {dac_hi, 8'h00};
  assign rfc = {8'h00, rfc_hi, 4'h0};
  assign hit = (paddr == OFS_DAC) || (paddr == OFS_RFC) ||
    (paddr == OFS_CFG) || (paddr == OFS_CMP) || (paddr == OFS_STS);
  assign wr = psel && penable && pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;

  always_comb begin
    rd = 16'h0000;
    if (paddr == OFS_DAC) begin
      rd = dac;
    end else if (paddr == OFS_RFC) begin
      rd = rfc;
    end else if (paddr == OFS_CFG) begin
      rd = {14'h0000, cfg};
    end else if (paddr == OFS_CMP) begin
      rd = {8'h00, cmp};
    end else if (paddr == OFS_STS) begin
      rd = {5'h00, fsm_state, flag, 7'h00};
    end
  end

  // Read data is captured in the setup cycle for a zero-wait answer
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= {16'h0000, rd};
    end
  end

  // Power-on reset only; manual reset never reaches here
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      dac_hi <= DAC_RST;
      rfc_hi <= RFC_RST;
      cfg <= CFG_RST;
      cmp <= CMP_RST;
    end else if (wr) begin
      if (paddr == OFS_DAC && pstrb[1]) begin
        dac_hi <= pwdata[15:8];
      end
      if (paddr == OFS_RFC && pstrb[1:0] == 2'b11 &&
          pwdata[15:8] == RFC_KEY) begin
        rfc_hi <= pwdata[7:4];
      end
      if (paddr == OFS_CFG && pstrb[0]) begin
        cfg <= pwdata[1:0];
      end
      if (paddr == OFS_CMP && pstrb[0]) begin
        cmp <= pwdata[7:0];
      end
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      flag <= 1'b0;
    end else if (match) begin
      flag <= 1'b1;
    end else if (wr && paddr == OFS_STS && pstrb[0] &&
        !pwdata[STS_FLAG]) begin
      flag <= 1'b0;
    end
  end

  AST_KEY_GUARD: assert property (@(posedge clk) disable iff (!rst_b)
    wr && paddr == OFS_RFC && pwdata[15:8] != RFC_KEY
    |=> $stable(rfc))
    else $error("refresh control changed without key");
endmodule // drac_apb
`default_nettype wire

/* drac_dram_model.sv */
`timescale 1ns/1ps
`default_nettype none
module drac_dram_model
  import drac_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clr,
  input wire logic ras_b,
  input wire logic cas_high_byte_b,
  input wire logic cas_low_byte_b,
  input wire logic write_strobe_high_b,
  input wire logic write_strobe_low_b,
  input wire logic [AW-1:0] dram_addr,
  output logic [4:0] seen,
  output var int n_row,
  output var int n_cbr,
  output var int cas_len,
  output logic [AW-1:0] row,
  output logic [AW-1:0] col
);
  logic ras_q;
  logic cas_q;
  int run;

  // No data pins here, so the model only watches strobes and address
  always_ff @(posedge clk) begin
    if (!rst_b || clr) begin
      seen <= 5'h00;
    end else begin
      seen <= seen | ~{ras_b, cas_high_byte_b, cas_low_byte_b,
        write_strobe_high_b, write_strobe_low_b};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ras_q <= 1'b1;
      cas_q <= 1'b1;
      run <= 0;
      n_row <= 0;
      n_cbr <= 0;
      cas_len <= 0;
      row <= '0;
      col <= '0;
    end else begin
      ras_q <= ras_b;
      cas_q <= cas_low_byte_b;
      run <= cas_low_byte_b ? 0 : run + 1;
      if (!cas_q && cas_low_byte_b) begin
        cas_len <= run;
      end
      // Column latched only with a row open; CAS first means refresh
      if (cas_q && !cas_low_byte_b && !ras_b) begin
        col <= dram_addr;
      end
      if (ras_q && !ras_b && cas_low_byte_b) begin
        n_row <= n_row + 1;
        row <= dram_addr;
      end
      if (ras_q && !ras_b && !cas_low_byte_b) begin
        n_cbr <= n_cbr + 1;
      end
    end
  end
endmodule // drac_dram_model
`default_nettype wire

/* tb_drac_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_drac_ctrl
  import drac_pkg::*;
;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic man_rst_b = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic req = 1'b0;
  logic [AW-1:0] req_addr = '0;
  logic req_write = 1'b0;
  logic req_wide = 1'b0;
  logic req_hi = 1'b0;
  logic req_lo = 1'b0;
  logic clr = 1'b0;
  logic [31:0] prdata, rd_v;
  logic pready, pslverr, req_ready, ack, ras_b, err_v;
  logic cas_high_byte_b, cas_low_byte_b;
  logic write_strobe_high_b, write_strobe_low_b;
  logic [AW-1:0] dram_addr, row, col;
  logic [4:0] seen;
  int n_row, n_cbr, cas_len, lat;
  int n_errors = 0;
  int n_tests = 0;

  drac_ctrl dut (
    .clk, .rst_b, .man_rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .req, .req_addr, .req_write,
    .req_wide, .req_hi, .req_lo, .req_ready, .ack, .ras_b,
    .cas_high_byte_b, .cas_low_byte_b, .write_strobe_high_b,
    .write_strobe_low_b, .dram_addr
  );
  drac_dram_model mem (
    .clk, .rst_b, .clr, .ras_b, .cas_high_byte_b, .cas_low_byte_b,
    .write_strobe_high_b, .write_strobe_low_b, .dram_addr, .seen,
    .n_row, .n_cbr, .cas_len, .row, .col
  );

  initial begin
    forever #25 clk = ~clk;
  end

  task automatic conclude();
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic bad(string m);
    n_errors++;
    $display("[ERR] %0t %s", $time, m);
  endtask

  task automatic hang();
    bad("wait ran out");
    conclude();
  endtask

  task automatic chk(logic [31:0] g, logic [31:0] e, string m);
    n_tests++;
    if (g !== e) bad(m);
  endtask

  task automatic tk(int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic apb(logic w, logic [7:0] a, logic [31:0] d, logic [3:0] s);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) hang();
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d, logic [3:0] s);
    apb(1'b1, a, d, s);
  endtask

  task automatic rd(logic [7:0] a, logic [31:0] e);
    apb(1'b0, a, 32'h0, 4'h0);
    chk(rd_v, e, "register read");
  endtask

  task automatic dac(logic [7:0] f);
    wr(OFS_DAC, {16'h0, f, 8'h00}, 4'hf);
  endtask

  // Keyed word write, reserved low bits kept zero
  task automatic rfc(logic [7:0] v);
    wr(OFS_RFC, {16'h0, RFC_KEY, v}, 4'h3);
  endtask

  task automatic mrst();
    man_rst_b <= 1'b0;
    tk(2);
    man_rst_b <= 1'b1;
    tk(1);
  endtask

  task automatic acc(logic [AW-1:0] a, logic w, logic wd);
    int k;
    clr <= 1'b1;
    req <= 1'b1;
    req_addr <= a;
    req_write <= w;
    req_wide <= wd;
    req_hi <= wd;
    req_lo <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      clr <= 1'b0;
      k++;
    end while (req_ready !== 1'b1 && k < 400);
    if (req_ready !== 1'b1) hang();
    req <= 1'b0;
    lat = 0;
    do begin
      @(posedge clk);
      lat++;
    end while (ack !== 1'b1 && lat < 300);
    if (ack !== 1'b1) hang();
  endtask

  task automatic s_regs();
    int k;
    rd(OFS_DAC, 32'h0);
    rd(OFS_RFC, 32'h0);
    wr(OFS_DAC, 32'h0000ffff, 4'hf);
    rd(OFS_DAC, 32'h0000ff00);
    wr(OFS_RFC, 32'h000000f0, 4'h3);
    rd(OFS_RFC, 32'h0);
    wr(OFS_RFC, 32'h00005af0, 4'h1);
    rd(OFS_RFC, 32'h0);
    wr(OFS_RFC, 32'h00005aff, 4'h3);
    rd(OFS_RFC, 32'h000000f0);
    mrst();
    rd(OFS_DAC, 32'h0000ff00);
    rd(OFS_RFC, 32'h000000f0);
    apb(1'b0, 8'h20, 32'h0, 4'h0);
    chk(err_v, 32'h1, "unmapped");
    rfc(8'h00);
    dac(8'h00);
    req <= 1'b1;
    req_lo <= 1'b1;
    k = 0;
    repeat (60) begin
      @(posedge clk);
      if (req_ready !== 1'b0) k++;
    end
    req <= 1'b0;
    chk(k, 0, "taken while off");
    wr(OFS_CFG, 32'h1, 4'h1);
  endtask

  task automatic s_strobes();
    logic [7:0] t [6] = '{8'h7d, 8'hf7, 8'h35, 8'hb5, 8'h5c, 8'hd4};
    foreach (t[i]) begin
      dac({t[i][7], 7'h00});
      acc(AW'(28'h0123456 + i), t[i][5], t[i][6]);
      chk(lat, 2 * STATE_CYC, "full latency");
      chk(seen, t[i][4:0], "strobe set");
      chk(row, 28'h0123456 + i, "row out");
      tk(3);
      chk(ras_b, 32'h1, "ras up");
    end
  endtask

  task automatic s_mux();
    for (int s = 0; s < 3; s++) begin
      dac({5'h00, 1'b1, s[1:0]});
      acc(28'h9abcdef, 1'b0, 1'b1);
      chk(row, 28'h9abcdef >> (8 + s), "shifted row");
      chk(col, 28'h9abcdef, "column");
    end
  endtask

  task automatic s_duty();
    for (int d = 0; d < 2; d++) begin
      dac({4'h0, d[0], 3'h0});
      acc(28'h0000100, 1'b0, 1'b1);
      tk(3);
      chk(cas_len, STATE_CYC - (d ? CAS_HI_35 : CAS_HI_50), "duty");
    end
  endtask

  task automatic s_burst();
    logic [AW-1:0] a;
    int n;
    a = 28'h5555555;
    for (int t = 0; t < 2; t++) begin
      for (int s = 0; s < 3; s++) begin
        mrst();
        dac({2'b01, t[0], 3'b100, s[1:0]});
        acc(a, 1'b0, 1'b1);
        tk(30);
        chk(ras_b, 32'h0, "ras held");
        n = n_row;
        acc(a ^ (28'h1 << (7 + s)), 1'b0, 1'b1);
        chk(lat, STATE_CYC, "page hit");
        chk(n_row, n, "row reissued");
        chk(col, a ^ (28'h1 << (7 + s)), "hit column");
        acc(a ^ (28'h1 << (8 + s)), 1'b0, 1'b1);
        chk(lat, (3 + t) * STATE_CYC, "page miss");
        chk(n_row, n + 1, "row reopened");
      end
    end
  endtask

  // Second refresh after a change, so the old setting has drained
  task automatic wcbr();
    int n0, k;
    n0 = n_cbr;
    k = 0;
    while (n_cbr < n0 + 2 && k < 3000) begin
      @(posedge clk);
      k++;
    end
    if (n_cbr < n0 + 2) hang();
    tk(8 * STATE_CYC);
  endtask

  task automatic s_refresh();
    int n;
    dac(8'h00);
    wr(OFS_CMP, 32'h10, 4'h1);
    rfc(8'h40);
    n = n_cbr;
    // Timer may need a full wrap before it meets the new compare
    tk(5400);
    chk(n_cbr, n, "refresh while off");
    chk(ras_b, 32'h1, "self while off");
    apb(1'b0, OFS_STS, 32'h0, 4'h0);
    chk(rd_v[STS_FLAG], 32'h1, "match flag");
    wr(OFS_STS, 32'h0, 4'h1);
    rfc(8'hb0);
    wcbr();
    chk(cas_len, STATE_CYC, "no waits");
    wr(OFS_CFG, 32'h3, 4'h1);
    for (int k = 0; k < 4; k++) begin
      rfc({2'b10, k[1:0], 4'h0});
      wcbr();
      chk(cas_len, (2 + k) * STATE_CYC, "wait states");
    end
    wr(OFS_CFG, 32'h1, 4'h1);
    rfc(8'hc0);
    tk(100);
    chk({ras_b, cas_low_byte_b}, 32'h0, "self refresh");
    rfc(8'h80);
    rfc(8'h00);
    tk(200);
    chk({ras_b, cas_low_byte_b}, 32'h3, "self exit");
    acc(28'h0000200, 1'b1, 1'b1);
    chk(lat, 2 * STATE_CYC, "access after exit");
  endtask

  initial begin
    tk(10);
    rst_b <= 1'b1;
    tk(1);
    s_regs();
    s_strobes();
    s_mux();
    s_duty();
    s_burst();
    s_refresh();
    conclude();
  end
endmodule // tb_drac_ctrl
`default_nettype wire
